// ### ifeb_interrupt_flag_enable_bank.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
//
// Contract
// - a source condition sets its flag whatever its enable holds.
// - each source has its own enable; pending request forwarded only when enabled. Pin events and group requests reach irq_o ignoring primary enables.
// - a flag reads 1 while its request is pending, else 0.
// - three primary control registers, numbered 0 to 2.
// - four shared group registers, numbered 0 to 3.
// - one edge-select register chooses trigger edge for each external pin.
// - primary 0: global bit0, pin0 bits 1/4, groups 0,1 bits 2,3/5,6.
// - primary 1: group2 0/4, group3 1/5, converter 2/6, timebase0 3/7.
// - primary 2: timebase1 0/4, pin1 1/5, async serial 2/6.
// - group 3: low voltage 0/4, serial iface 1/5, port A 2/6, eeprom 3/7.
// - groups 0-2: timers' period/compare enables bits 0-3, flags bits 4-7.
// - edge field 00 off, 01 rising, 10 falling, 11 both; pin1 3:2, pin0 1:0.
// - global enable 0 blocks every request to the core.
//
module ifeb_interrupt_flag_enable_bank
  import ifeb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] ext_pin_i,
  input wire logic converter_evt_i,
  input wire logic [1:0] timebase_evt_i,
  input wire logic serial_async_evt_i,
  input wire logic low_voltage_evt_i,
  input wire logic serial_iface_evt_i,
  input wire logic serial_port_a_evt_i,
  input wire logic eeprom_write_evt_i,
  input wire logic [5:0] timer_period_evt_i,
  input wire logic [5:0] timer_compare_evt_i,
  output logic core_irq_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] edge_reg;
  logic [7:0] pri_reg [3];
  logic [7:0] grp_reg [4];
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic [7:0] rdata_reg;
  logic core_irq_reg;
  logic irq_reg;
  logic [1:0] pin_evt;
  logic [3:0] grp_set [4];
  logic [3:0] grp_active;
  logic [3:0] pri_set [3];
  logic [3:0] pri_active [3];
  logic any_pri;
  logic [2:0] stat_evt;

  // True when a write hits the given index
  function automatic logic wr_hit(input logic [3:0] a);
    return wr_i && (addr_i == a);
  endfunction

  // Flag bits: set wins over a software write of the same cycle
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic hit,
                                     input logic [7:0] wd, input logic [3:0] set,
                                     input logic [7:0] msk);
    logic [7:0] v;
    v = hit ? (wd & msk) : cur;
    return v | ({set, 4'h0} & msk);
  endfunction

  // Pending and enabled, nibble by nibble
  function automatic logic [3:0] active(input logic [7:0] r);
    return r[7:4] & r[3:0];
  endfunction

  // ---------------------------------------------------------------
  // External pins
  // ---------------------------------------------------------------
  ifeb_pin_edge u_pin0 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_pin_i[0]),
    .sel_i(edge_reg[EDGE_P0_LSB +: 2]),
    .event_o(pin_evt[0])
  );

  ifeb_pin_edge u_pin1 (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_pin_i[1]),
    .sel_i(edge_reg[EDGE_P1_LSB +: 2]),
    .event_o(pin_evt[1])
  );

  // ---------------------------------------------------------------
  // Source-to-flag mapping
  // ---------------------------------------------------------------
  // Shared groups 0-2 hold two timers each
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_timer
      assign grp_set[g] = {timer_compare_evt_i[2*g+1], timer_period_evt_i[2*g+1],
                           timer_compare_evt_i[2*g], timer_period_evt_i[2*g]};
    end
  endgenerate
  assign grp_set[3] = {eeprom_write_evt_i, serial_port_a_evt_i,
                       serial_iface_evt_i, low_voltage_evt_i};

  // Group request when any enabled member is pending
  generate
    for (g = 0; g < 4; g++) begin : g_grp
      assign grp_active[g] = |active(grp_reg[g]);
    end
  endgenerate

  // Primary flag sources; bit 7 of primary 0 and 3,7 of primary 2 unused
  assign pri_set[0] = {1'b0, grp_active[1], grp_active[0], pin_evt[0]};
  assign pri_set[1] = {timebase_evt_i[0], converter_evt_i,
                       grp_active[3], grp_active[2]};
  assign pri_set[2] = {1'b0, serial_async_evt_i, pin_evt[1], timebase_evt_i[1]};

  // Primary 0 flags 6:4 pair with enables 3:1; bit 0 is the global gate, not an enable
  assign pri_active[0] = {1'b0, pri_reg[0][6:4] & pri_reg[0][3:1]};
  assign pri_active[1] = active(pri_reg[1]);
  assign pri_active[2] = active(pri_reg[2]);
  assign any_pri = |{pri_active[0], pri_active[1], pri_active[2]};

  // ---------------------------------------------------------------
  // Edge select register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_reg <= REG_RESET;
    end else if (wr_hit(ADDR_EDGE)) begin
      edge_reg <= wdata_i & EDGE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Primary control registers
  // ---------------------------------------------------------------
  // Flags set regardless of enables; software may clear by writing 0
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pri_reg[0] <= REG_RESET;
      pri_reg[1] <= REG_RESET;
      pri_reg[2] <= REG_RESET;
    end else begin
      pri_reg[0] <= upd(pri_reg[0], wr_hit(ADDR_PRI0), wdata_i, pri_set[0], PRI0_MASK);
      pri_reg[1] <= upd(pri_reg[1], wr_hit(ADDR_PRI1), wdata_i, pri_set[1], FULL_MASK);
      pri_reg[2] <= upd(pri_reg[2], wr_hit(ADDR_PRI2), wdata_i, pri_set[2], PRI2_MASK);
    end
  end

  // ---------------------------------------------------------------
  // Shared group registers
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_grp_reg
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          grp_reg[g] <= REG_RESET;
        end else begin
          grp_reg[g] <= upd(grp_reg[g], wr_hit(ADDR_GRP0 + 4'(g)), wdata_i,
                            grp_set[g], FULL_MASK);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Core request
  // ---------------------------------------------------------------
  // Registered so the output is glitch free; adds one cycle latency
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_irq_reg <= 1'b0;
    end else begin
      core_irq_reg <= pri_reg[0][GLOBAL_EN_BIT] && any_pri;
    end
  end

  // ---------------------------------------------------------------
  // Sticky status: bit0 pin event, bit1 group request, bit2 core request
  // ---------------------------------------------------------------
  assign stat_evt = {pri_reg[0][GLOBAL_EN_BIT] && any_pri, |grp_active, |pin_evt};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
    end else begin
      // Write one to clear; a new event in the same cycle wins
      stat_reg <= (stat_reg & ~(wr_hit(ADDR_IRQ_STATUS) ? wdata_i[2:0] : 3'h0)) | stat_evt;
      if (wr_hit(ADDR_IRQ_MASK)) begin
        mask_reg <= wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // Read port, data valid the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_EDGE: rdata_reg <= edge_reg;
        ADDR_PRI0: rdata_reg <= pri_reg[0];
        ADDR_PRI1: rdata_reg <= pri_reg[1];
        ADDR_PRI2: rdata_reg <= pri_reg[2];
        ADDR_GRP0: rdata_reg <= grp_reg[0];
        ADDR_GRP1: rdata_reg <= grp_reg[1];
        ADDR_GRP2: rdata_reg <= grp_reg[2];
        ADDR_GRP3: rdata_reg <= grp_reg[3];
        ADDR_IRQ_STATUS: rdata_reg <= {5'h00, stat_reg & STAT_MASK[2:0]};
        ADDR_IRQ_MASK: rdata_reg <= {5'h00, mask_reg};
        default: rdata_reg <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_o = rdata_reg;
  assign core_irq_o = core_irq_reg;
  assign irq_o = irq_reg;
endmodule

// ### ifeb_pkg.sv
package ifeb_pkg;
  // ---------------------------------------------------------------
  // Register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_EDGE = 4'h0;
  localparam logic [3:0] ADDR_PRI0 = 4'h1;
  localparam logic [3:0] ADDR_PRI1 = 4'h2;
  localparam logic [3:0] ADDR_PRI2 = 4'h3;
  localparam logic [3:0] ADDR_GRP0 = 4'h4;
  localparam logic [3:0] ADDR_GRP1 = 4'h5;
  localparam logic [3:0] ADDR_GRP2 = 4'h6;
  localparam logic [3:0] ADDR_GRP3 = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;

  // ---------------------------------------------------------------
  // Reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] EDGE_MASK = 8'h0f;
  localparam logic [7:0] PRI0_MASK = 8'h7f;
  localparam logic [7:0] PRI2_MASK = 8'h77;
  localparam logic [7:0] FULL_MASK = 8'hff;
  localparam logic [7:0] STAT_MASK = 8'h07;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 0;
  localparam int FLAG_OFS = 4;
  localparam int EDGE_P1_LSB = 2;
  localparam int EDGE_P0_LSB = 0;

  // Edge-select encodings
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Pin edge detector states, Gray coded
  typedef enum logic [1:0] {
    IFEB_LOW = 2'b00,
    IFEB_RISEN = 2'b01,
    IFEB_HIGH = 2'b11,
    IFEB_FELL = 2'b10
  } ifeb_pin_state_t;
endpackage

// ### ifeb_pin_edge.sv
`timescale 1ns/1ps
// External pin synchroniser and edge detector
module ifeb_pin_edge
  import ifeb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic [1:0] sel_i,
  output logic event_o
);
  logic sync1_reg;
  logic sync2_reg;
  ifeb_pin_state_t state_reg;
  ifeb_pin_state_t state_next;

  // ---------------------------------------------------------------
  // Two-stage synchroniser; only the second stage is read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Level tracker marks the cycle after each transition
  always_comb begin
    case (state_reg)
      IFEB_LOW: state_next = sync2_reg ? IFEB_RISEN : IFEB_LOW;
      IFEB_RISEN: state_next = sync2_reg ? IFEB_HIGH : IFEB_FELL;
      IFEB_HIGH: state_next = sync2_reg ? IFEB_HIGH : IFEB_FELL;
      IFEB_FELL: state_next = sync2_reg ? IFEB_RISEN : IFEB_LOW;
      default: state_next = IFEB_LOW;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= IFEB_LOW;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edge qualified by the two-bit select field
  always_comb begin
    case (sel_i)
      EDGE_RISE: event_o = (state_reg == IFEB_RISEN);
      EDGE_FALL: event_o = (state_reg == IFEB_FELL);
      EDGE_BOTH: event_o = (state_reg == IFEB_RISEN) || (state_reg == IFEB_FELL);
      default: event_o = 1'b0; // Disabled
    endcase
  end
endmodule

// ### ifeb_src_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Peripheral event sources: one-cycle pulse per request rise
// ---------------------------------------------------------------
module ifeb_src_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [19:0] fire_i,
  output logic [19:0] evt_o
);
  logic [19:0] fire_reg;
  // Edge of the request only, so a held request never repeats the event
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fire_reg <= '0;
      evt_o <= '0;
    end else begin
      fire_reg <= fire_i;
      evt_o <= fire_i & ~fire_reg;
    end
  end
endmodule

// ### ifeb_interrupt_flag_enable_bank_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port-level checker of the flag and enable bank
// ---------------------------------------------------------------
module ifeb_interrupt_flag_enable_bank_sva
  import ifeb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic core_irq_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Read data only in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data seen without a read");
  AST_UNMAPPED_READ: assert property (rd_i && addr_i > ADDR_IRQ_MASK |=> rdata_o == 8'h00)
    else $error("unmapped index gave data");
  AST_PRI0_UNUSED: assert property (rd_i && addr_i == ADDR_PRI0 |=> !rdata_o[7])
    else $error("primary 0 bit 7 set");
  AST_PRI2_UNUSED: assert property (rd_i && addr_i == ADDR_PRI2 |=> (rdata_o & 8'h88) == 8'h00)
    else $error("primary 2 unused bits set");
  // Write then read of the edge register, no gap between
  AST_EDGE_RDBACK: assert property (wr_i && addr_i == ADDR_EDGE ##1 rd_i && addr_i == ADDR_EDGE
    |=> rdata_o == ($past(wdata_i, 2) & 8'h0f))
    else $error("edge select read back wrong");
  AST_EDGE_HOLD: assert property (rd_i && addr_i == ADDR_EDGE ##1 rd_i && addr_i == ADDR_EDGE
    |=> rdata_o == $past(rdata_o))
    else $error("edge select changed without a write");
  // Written ones survive: sources may only add flags
  AST_PRI1_WRITE: assert property (wr_i && addr_i == ADDR_PRI1 ##1 rd_i && addr_i == ADDR_PRI1
    |=> (rdata_o & $past(wdata_i, 2)) == $past(wdata_i, 2))
    else $error("primary 1 lost written bits");
  AST_GLOBAL_GATE: assert property (wr_i && addr_i == ADDR_PRI0 && !wdata_i[0]
    |=> ##1 !core_irq_o)
    else $error("core request with global enable off");
  AST_MASK_GATE: assert property (wr_i && addr_i == ADDR_IRQ_MASK && wdata_i == 8'h00
    |=> ##1 !irq_o)
    else $error("interrupt with all bits masked");

  cover property ($rose(core_irq_o));
  cover property ($rose(irq_o));
  cover property (rd_i && addr_i > ADDR_IRQ_MASK);
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import ifeb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] ext_pin_i = 2'h0;
  logic [19:0] fire = '0;
  logic [19:0] evt;
  logic [7:0] rdata_o;
  logic core_irq_o;
  logic irq_o;
  logic [7:0] q;
  int mismatches = 0;
  int n_compared = 0;
  // Rows: register index and the lone flag each source sets
  logic [11:0] rows [20] = '{12'h240, 12'h280, 12'h310, 12'h340, 12'h710, 12'h720, 12'h740,
    12'h780, 12'h410, 12'h440, 12'h510, 12'h540, 12'h610, 12'h640, 12'h420, 12'h480,
    12'h520, 12'h580, 12'h620, 12'h680};

  always #12.5 clk_sys_i = ~clk_sys_i;

  ifeb_src_model ifeb_src_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .fire_i(fire), .evt_o(evt));
  ifeb_interrupt_flag_enable_bank ifeb_interrupt_flag_enable_bank_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_pin_i(ext_pin_i),
    .converter_evt_i(evt[0]), .timebase_evt_i(evt[2:1]), .serial_async_evt_i(evt[3]),
    .low_voltage_evt_i(evt[4]), .serial_iface_evt_i(evt[5]), .serial_port_a_evt_i(evt[6]),
    .eeprom_write_evt_i(evt[7]), .timer_period_evt_i(evt[13:8]),
    .timer_compare_evt_i(evt[19:14]), .core_irq_o(core_irq_o), .irq_o(irq_o));

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Write or read, then a read of the same index with no gap
  task b2b(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  task fire_src(input int i);
    @(posedge clk_sys_i);
    fire <= 20'h1 << i;
    @(posedge clk_sys_i);
    fire <= '0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Interrupt lines: sel 0 core request, sel 1 status interrupt; settled 1 ns past the edge
  task chk_lvl(input string nm, input logic e, input logic sel);
    logic g;
    #1 g = sel ? irq_o : core_irq_o;
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), q);
      chk("reset value", 8'h00, q);
    end
    wr(4'hf, 8'hff);
    rd(4'hf, q);
    chk("unmapped", 8'h00, q);
    wr(ADDR_PRI0, 8'hff);
    rd(ADDR_PRI0, q);
    chk("primary 0 bits", 8'h7f, q);
    wr(ADDR_PRI2, 8'hff);
    rd(ADDR_PRI2, q);
    chk("primary 2 bits", 8'h77, q);
    wr(ADDR_PRI0, 8'h00);
    wr(ADDR_PRI2, 8'h00);
    // Each source with every enable off: flag set, then cleared
    for (int i = 0; i < 20; i++) begin
      fire_src(i);
      rd(rows[i][11:8], q);
      chk("source flag", rows[i][7:0], q);
      wr(rows[i][11:8], 8'h00);
      rd(rows[i][11:8], q);
      chk("cleared flag", 8'h00, q);
    end
    // Global and individual gating
    b2b(1'b1, ADDR_PRI1, 8'h04, q);
    chk("primary 1", 8'h04, q);
    fire_src(0);
    chk_lvl("core gated", 1'b0, 1'b0);
    wr(ADDR_PRI0, 8'h01);
    repeat (3) @(posedge clk_sys_i);
    chk_lvl("core request", 1'b1, 1'b0);
    wr(ADDR_PRI1, 8'h40);
    repeat (3) @(posedge clk_sys_i);
    chk_lvl("core disabled", 1'b0, 1'b0);
    rd(ADDR_PRI1, q);
    chk("flag kept", 8'h40, q);
    // Shared group request through group 3
    wr(ADDR_GRP3, 8'h01);
    wr(ADDR_PRI1, 8'h02);
    fire_src(4);
    rd(ADDR_PRI1, q);
    chk("group flag", 8'h22, q);
    chk_lvl("group core", 1'b1, 1'b0);
    wr(ADDR_GRP3, 8'h00);
    wr(ADDR_PRI1, 8'h00);
    wr(ADDR_PRI0, 8'h00);
    // Primary 0 pairs each flag with the enable three bits below it
    wr(ADDR_PRI0, 8'h13);
    repeat (2) @(posedge clk_sys_i);
    chk_lvl("pin 0 core", 1'b1, 1'b0);
    wr(ADDR_PRI0, 8'h23);
    repeat (2) @(posedge clk_sys_i);
    chk_lvl("group 0 not enabled", 1'b0, 1'b0);
    wr(ADDR_PRI0, 8'h00);
    // Every edge code on both pins
    for (int c = 0; c < 4; c++) begin
      b2b(1'b1, ADDR_EDGE, {4'h0, 2'(c), 2'(c)}, q);
      chk("edge select", {4'h0, 2'(c), 2'(c)}, q);
      ext_pin_i <= 2'h3;
      repeat (6) @(posedge clk_sys_i);
      rd(ADDR_PRI0, q);
      chk("pin 0 rise", {3'h0, c[0], 4'h0}, q);
      rd(ADDR_PRI2, q);
      chk("pin 1 rise", {2'h0, c[0], 5'h0}, q);
      wr(ADDR_PRI0, 8'h00);
      wr(ADDR_PRI2, 8'h00);
      ext_pin_i <= 2'h0;
      repeat (6) @(posedge clk_sys_i);
      rd(ADDR_PRI0, q);
      chk("pin 0 fall", {3'h0, c[1], 4'h0}, q);
      rd(ADDR_PRI2, q);
      chk("pin 1 fall", {2'h0, c[1], 5'h0}, q);
      wr(ADDR_PRI0, 8'h00);
      wr(ADDR_PRI2, 8'h00);
    end
    b2b(1'b0, ADDR_EDGE, 8'h00, q);
    chk("edge held", 8'h0f, q);
    // Sticky status, mask and write-one clear
    wr(ADDR_IRQ_STATUS, 8'h07);
    ext_pin_i <= 2'h1;
    repeat (6) @(posedge clk_sys_i);
    rd(ADDR_IRQ_STATUS, q);
    chk("status", 8'h01, q);
    chk_lvl("irq masked", 1'b0, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk_lvl("irq unmasked", 1'b1, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk_lvl("irq cleared", 1'b0, 1'b1);
    rd(ADDR_IRQ_STATUS, q);
    chk("status cleared", 8'h00, q);
    wr(ADDR_IRQ_MASK, 8'h00);
    // Reset in mid-run
    wr(ADDR_PRI1, 8'hff);
    wr(ADDR_PRI0, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    chk_lvl("core before reset", 1'b1, 1'b0);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(ADDR_PRI1, q);
    chk("second reset", 8'h00, q);
    chk_lvl("core after reset", 1'b0, 1'b0);
    finish_test();
  end
endmodule

bind ifeb_interrupt_flag_enable_bank ifeb_interrupt_flag_enable_bank_sva ifeb_sva_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_irq_o(core_irq_o), .irq_o(irq_o));
